/* design/spi_core_pkg.sv */
// Summary of operation
// - master drives data, clock, active-low selects
// - each transfer sends and receives simultaneously
// - selected slaves asserted, others held deasserted
// - slave takes data, clock, select; drives out
// - phase-0 slave shifts immediately once select asserts
// - unselected slave still drives master-in level
// - enabled interrupts for receive and transmit ready
// - plain writes or flow-controlled writes, selectable
// - select output count is parameter 1..32
// - serial clock is system clock over even factor
// - optional select-to-clock delay in half periods
// - one shared data width from 1 to 32
// - shift direction parameter, msb or lsb first
// - polarity sets serial clock idle level
// - phase chooses sampling on leading or trailing
// - role fixed by parameter, not runtime
// - holding word loads shifter when idle and not yet sent
// - finished word copied to receive holding
package spi_core_pkg;

  localparam int unsigned CLK_HZ         = 40_000_000;
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned SCLK_TARGET_HZ = 1_000_000;
  localparam int unsigned DELAY_NS       = 1000;
  localparam int unsigned MAX_WIDTH      = 32;
  localparam int unsigned MAX_SLAVES     = 32;

  // half period in system clocks, rounded up so rate never exceeds target
  function automatic int unsigned half_div(input int unsigned target_hz);
    int unsigned h;
    h = (CLK_HZ + 2 * target_hz - 1) / (2 * target_hz);
    return (h < 1) ? 1 : h;
  endfunction : half_div

  // delay in half periods, rounded up
  function automatic int unsigned delay_halves(input int unsigned ns,
                                               input int unsigned half);
    int unsigned p;
    int unsigned d;
    p = half * CLK_PERIOD_NS;
    d = (ns + p - 1) / p;
    return (d < 1) ? 1 : d;
  endfunction : delay_halves

  typedef struct packed {
    logic rx_valid;
    logic tx_ready;
    logic rx_overrun;
    logic tx_overrun;
  } status_s;

  localparam status_s STATUS_RST = '{rx_valid: 1'b0, tx_ready: 1'b1,
                                     rx_overrun: 1'b0, tx_overrun: 1'b0};

  typedef enum logic [1:0] {
    st_idle,
    st_delay,
    st_shift,
    st_end
  } master_state_e;

endpackage : spi_core_pkg

/* design/spi_sync2.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_sync2 #(
  parameter int unsigned W               = 1,
  parameter logic [W-1:0] RST_VAL        = '0
) (
  // clock and reset
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic         ce,
  // async in, synced out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end
    else if (ce)
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : spi_sync2
`default_nettype wire

/* design/spi_tick_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_tick_gen #(
  parameter int unsigned HALF = 1
) (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic ce,
  // control
  input  wire logic run,
  output logic      tick
);

  localparam int unsigned CW = (HALF < 2) ? 1 : $clog2(HALF);
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);

  logic [CW-1:0] cnt_r;

  // one pulse per half serial period, factor two overall
  assign tick = run && (cnt_r == LAST);

  always_ff @(posedge core_clk)
  begin
    if (rst)
      cnt_r <= '0;
    else if (ce)
    begin
      if (!run || tick)
        cnt_r <= '0;
      else
        cnt_r <= cnt_r + CW'(1);
    end
  end

endmodule : spi_tick_gen
`default_nettype wire

/* design/spi_master_slave_core.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_master_slave_core #(
  parameter bit          IS_MASTER  = 1'b1,
  parameter int unsigned NUM_SLAVES = 1,
  parameter int unsigned WIDTH      = 8,
  parameter bit          MSB_FIRST  = 1'b1,
  parameter bit          CPOL       = 1'b0,
  parameter bit          CPHA       = 1'b0,
  parameter int unsigned SCLK_HZ    = spi_core_pkg::SCLK_TARGET_HZ,
  parameter bit          DELAY_EN   = 1'b0,
  parameter int unsigned DELAY_NS   = spi_core_pkg::DELAY_NS,
  parameter bit          FLOW_CTRL  = 1'b1
) (
  // clock, reset, enable
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  // host transmit side
  input  wire logic [WIDTH-1:0]      tx_data,
  input  wire logic                  tx_write,
  // host receive side
  output logic      [WIDTH-1:0]      rx_data,
  input  wire logic                  rx_read,
  // host control and status
  input  wire logic                  status_clear,
  input  wire logic [NUM_SLAVES-1:0] sel_mask,
  input  wire logic                  rx_irq_en,
  input  wire logic                  tx_irq_en,
  output spi_core_pkg::status_s      status,
  output logic                       busy,
  output logic                       irq,
  // master pins
  output logic                       sclk_out,
  output logic                       mosi_out,
  input  wire logic                  miso_in,
  output logic      [NUM_SLAVES-1:0] slave_select_out_m_n,
  // slave pins
  input  wire logic                  sclk_in,
  input  wire logic                  mosi_in,
  input  wire logic                  select_in_n,
  output logic                       miso_out
);

  localparam int unsigned HALF = spi_core_pkg::half_div(SCLK_HZ);
  localparam int unsigned DLY  = spi_core_pkg::delay_halves(DELAY_NS, HALF);
  localparam int unsigned EW   = $clog2(2 * WIDTH + 1);
  localparam int unsigned BW   = $clog2(WIDTH + 1);
  localparam int unsigned DW   = $clog2(DLY + 1);
  localparam logic [EW-1:0] EDGE_LAST = EW'(2 * WIDTH - 1);
  localparam logic [BW-1:0] BIT_LAST  = BW'(WIDTH - 1);
  localparam logic [DW-1:0] DLY_LAST  = DW'(DLY - 1);
  localparam logic [3:0]    SYNC_RST  = {1'h0, CPOL, 2'h1};

  initial
  begin
    if (NUM_SLAVES < 1 || NUM_SLAVES > spi_core_pkg::MAX_SLAVES)
      $error("slave count out of range");
    if (WIDTH < 1 || WIDTH > spi_core_pkg::MAX_WIDTH)
      $error("data width out of range");
  end

  function automatic logic out_bit(input logic [WIDTH-1:0] sh);
    return MSB_FIRST ? sh[WIDTH-1] : sh[0];
  endfunction : out_bit

  function automatic logic [WIDTH-1:0] shift_out(input logic [WIDTH-1:0] sh);
    return MSB_FIRST ? (sh << 1) : (sh >> 1);
  endfunction : shift_out

  function automatic logic [WIDTH-1:0] shift_in(input logic [WIDTH-1:0] sh,
                                                input logic b);
    if (MSB_FIRST)
      return (sh << 1) | WIDTH'(b);
    return (sh >> 1) | (WIDTH'(b) << (WIDTH - 1));
  endfunction : shift_in

  // pins from outside pass two flops; select resets unselected
  logic miso_s;
  logic sclk_s;
  logic mosi_s;
  logic sel_n_s;

  spi_sync2 #(
    .W       (4),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .d        ({miso_in, sclk_in, mosi_in, select_in_n}),
    .q        ({miso_s, sclk_s, mosi_s, sel_n_s})
  );

  spi_core_pkg::master_state_e state_r;
  logic                  tick;
  logic [WIDTH-1:0]      tx_hold_r;
  logic [WIDTH-1:0]      tx_sh_r;
  logic [WIDTH-1:0]      rx_sh_r;
  logic [EW-1:0]         edge_cnt_r;
  logic [BW-1:0]         bit_cnt_r;
  logic [DW-1:0]         dly_cnt_r;
  logic                  sclk_d_r;
  logic                  sel_d_r;

  spi_tick_gen #(
    .HALF (HALF)
  ) u_tick (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .run      (IS_MASTER && state_r != spi_core_pkg::st_idle),
    .tick     (tick)
  );

  // event decode for both roles
  logic m_lead;
  logic m_sample;
  logic m_last;
  logic s_edge;
  logic s_lead;
  logic s_sample;
  logic s_change;
  logic selected;
  logic sel_start;
  logic idle;
  logic load;
  logic sample;
  logic done;
  logic rx_bit;
  logic wr_ok;

  assign m_lead    = ~edge_cnt_r[0];
  assign m_sample  = (m_lead == ~CPHA);
  assign m_last    = (edge_cnt_r == EDGE_LAST);
  assign selected  = ~sel_n_s;
  assign sel_start = selected & sel_d_r;
  assign s_edge    = selected & (sclk_s != sclk_d_r);
  assign s_lead    = (sclk_s != CPOL);
  assign s_sample  = s_edge & (s_lead ^ CPHA);
  assign s_change  = s_edge & ~(s_lead ^ CPHA);
  assign idle      = IS_MASTER ? (state_r == spi_core_pkg::st_idle)
                               : ~selected;
  assign load      = idle & ~status.tx_ready;
  assign sample    = IS_MASTER
                     ? (state_r == spi_core_pkg::st_shift && tick && m_sample)
                     : s_sample;
  assign rx_bit    = IS_MASTER ? miso_s : mosi_s;
  assign done      = sample & (IS_MASTER
                     ? (edge_cnt_r[EW-1:1] == EDGE_LAST[EW-1:1])
                     : (bit_cnt_r == BIT_LAST));
  assign wr_ok     = tx_write & status.tx_ready;

  // host holding registers and flags; hardware set beats host clear
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tx_hold_r <= '0;
      rx_data   <= '0;
      status    <= spi_core_pkg::STATUS_RST;
    end
    else if (ce)
    begin
      if (wr_ok)
        tx_hold_r <= tx_data;
      if (wr_ok)
        status.tx_ready <= 1'b0;
      else if (load)
        status.tx_ready <= 1'b1;
      if (tx_write && !status.tx_ready && !FLOW_CTRL)
        status.tx_overrun <= 1'b1;
      else if (status_clear)
        status.tx_overrun <= 1'b0;
      if (done)
      begin
        rx_data         <= shift_in(rx_sh_r, rx_bit);
        status.rx_valid <= 1'b1;
      end
      else if (rx_read)
        status.rx_valid <= 1'b0;
      if (done && status.rx_valid && !rx_read)
        status.rx_overrun <= 1'b1;
      else if (status_clear)
        status.rx_overrun <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      irq <= 1'b0;
    else if (ce)
      irq <= (rx_irq_en & status.rx_valid) |
             (tx_irq_en & status.tx_ready);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      sclk_d_r <= CPOL;
      sel_d_r  <= 1'b1;
    end
    else if (ce)
    begin
      sclk_d_r <= sclk_s;
      sel_d_r  <= sel_n_s;
    end
  end

  // master sequencer; role is a constant, so one branch is dead logic
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_r              <= spi_core_pkg::st_idle;
      edge_cnt_r           <= '0;
      dly_cnt_r            <= '0;
      sclk_out             <= CPOL;
      slave_select_out_m_n <= '1;
    end
    else if (ce && IS_MASTER)
    begin
      case (state_r)
        spi_core_pkg::st_idle:
        begin
          sclk_out             <= CPOL;
          edge_cnt_r           <= '0;
          dly_cnt_r            <= '0;
          if (load)
          begin
            slave_select_out_m_n <= ~sel_mask;
            state_r <= (DELAY_EN && DLY > 1) ? spi_core_pkg::st_delay
                                             : spi_core_pkg::st_shift;
          end
          else
            slave_select_out_m_n <= '1;
        end
        spi_core_pkg::st_delay:
        begin
          if (tick)
          begin
            dly_cnt_r <= dly_cnt_r + DW'(1);
            if (dly_cnt_r == DLY_LAST - DW'(1))
              state_r <= spi_core_pkg::st_shift;
          end
        end
        spi_core_pkg::st_shift:
        begin
          if (tick)
          begin
            sclk_out   <= ~sclk_out;
            edge_cnt_r <= edge_cnt_r + EW'(1);
            if (m_last)
              state_r <= spi_core_pkg::st_end;
          end
        end
        spi_core_pkg::st_end:
        begin
          if (tick)
          begin
            slave_select_out_m_n <= '1;
            state_r              <= spi_core_pkg::st_idle;
          end
        end
        default:
          state_r <= spi_core_pkg::st_idle;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      busy <= 1'b0;
    else if (ce)
      busy <= ~idle;
  end

  // shift registers and serial data out for both roles
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      tx_sh_r   <= '0;
      rx_sh_r   <= '0;
      bit_cnt_r <= '0;
      mosi_out  <= 1'b0;
      miso_out  <= 1'b0;
    end
    else if (ce)
    begin
      if (sample)
        rx_sh_r <= shift_in(rx_sh_r, rx_bit);
      if (IS_MASTER)
      begin
        if (load && !CPHA)
        begin
          mosi_out <= out_bit(tx_hold_r);
          tx_sh_r  <= shift_out(tx_hold_r);
        end
        else if (load)
          tx_sh_r <= tx_hold_r;
        else if (state_r == spi_core_pkg::st_shift && tick && !m_sample
                 && !m_last)
        begin
          mosi_out <= out_bit(tx_sh_r);
          tx_sh_r  <= shift_out(tx_sh_r);
        end
      end
      else
      begin
        if (load)
          tx_sh_r <= tx_hold_r;
        else if ((sel_start && !CPHA) || s_change)
        begin
          miso_out <= out_bit(tx_sh_r);
          tx_sh_r  <= shift_out(tx_sh_r);
        end
        // miso keeps its last level when unselected
        if (!selected)
          bit_cnt_r <= '0;
        else if (s_sample)
          bit_cnt_r <= done ? '0 : bit_cnt_r + BW'(1);
      end
    end
  end

endmodule : spi_master_slave_core
`default_nettype wire

/* testbench/spi_core_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_core_monitor #(
  parameter bit          IS_MASTER  = 1'b1,
  parameter int unsigned NUM_SLAVES = 1,
  parameter int unsigned WIDTH      = 8,
  parameter bit          CPOL       = 1'b0,
  parameter bit          CPHA       = 1'b0
) (
  // clock and reset
  input wire logic                  core_clk,
  input wire logic                  rst,
  // host side
  input wire logic                  tx_write,
  input wire logic [NUM_SLAVES-1:0] sel_mask,
  input wire logic                  rx_irq_en,
  input wire logic                  tx_irq_en,
  input wire spi_core_pkg::status_s status,
  input wire logic                  irq,
  // serial side
  input wire logic                  sclk_out,
  input wire logic                  mosi_out,
  input wire logic [NUM_SLAVES-1:0] slave_select_out_m_n
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  logic       idle;
  logic       act;
  logic       irq_want;
  logic [5:0] edges_r;
  assign idle     = &slave_select_out_m_n;
  assign act      = sclk_out ^ CPOL;
  assign irq_want = (rx_irq_en & status.rx_valid) |
                    (tx_irq_en & status.tx_ready);

  // leading edges seen within one selection
  always_ff @(posedge core_clk)
    if (rst || idle)
      edges_r <= 6'h00;
    else if ($rose(act))
      edges_r <= edges_r + 6'h01;

  sequence lead_in;
    !act [*3] ##[1:2] act;
  endsequence
  sequence high_half;
    act [*3] ##1 !act;
  endsequence

  clk_idle_a: assert property (idle |-> !act)
    else $error("serial clock off idle level");
  sel_mask_a: assert property ($fell(idle) |->
    slave_select_out_m_n == ~$past(sel_mask))
    else $error("selects differ from mask");
  ready_drop_a: assert property (tx_write && status.tx_ready |=>
    !status.tx_ready)
    else $error("write accepted but ready stayed");
  start_a: assert property (IS_MASTER && tx_write && status.tx_ready &&
    idle |->
    ##[1:3] !idle)
    else $error("write did not start transfer");
  lead_in_a: assert property ($fell(idle) |-> lead_in)
    else $error("first clock edge mistimed");
  half_period_a: assert property ($rose(act) |=> high_half)
    else $error("serial clock half period wrong");
  word_width_a: assert property ($rose(idle) |->
    edges_r == 6'(WIDTH))
    else $error("edge count differs from width");
  mosi_edge_a: assert property ($changed(mosi_out) && !idle &&
    !$fell(idle) |-> (CPHA ? $rose(act) : $fell(act)))
    else $error("data changed off its edge");
  rx_done_a: assert property ($rose(status.rx_valid) |->
    ##[1:8] idle)
    else $error("word done outside transfer end");
  irq_level_a: assert property (irq == $past(irq_want))
    else $error("interrupt level wrong");
endmodule : spi_core_monitor

bind spi_master_slave_core spi_core_monitor #(
  .IS_MASTER(IS_MASTER), .NUM_SLAVES(NUM_SLAVES), .WIDTH(WIDTH),
  .CPOL(CPOL), .CPHA(CPHA)
) u_spi_core_monitor (
  .core_clk(core_clk), .rst(rst), .tx_write(tx_write),
  .sel_mask(sel_mask), .rx_irq_en(rx_irq_en), .tx_irq_en(tx_irq_en),
  .status(status), .irq(irq), .sclk_out(sclk_out),
  .mosi_out(mosi_out), .slave_select_out_m_n(slave_select_out_m_n)
);
`default_nettype wire

/* testbench/spi_slave_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
  // serial pins
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       sel_n,
  output logic            miso,
  // word to send, word seen
  input  wire logic [7:0] word,
  output logic      [7:0] got
);
  logic [7:0] sh;
  initial
  begin
    miso = 1'b0;
    got  = 8'h00;
    sh   = 8'h00;
  end
  always @(negedge sel_n)
  begin
    sh   = word;
    miso = word[7];
  end
  always @(posedge sclk)
    if (!sel_n)
      got = {got[6:0], mosi};
  always @(negedge sclk)
    if (!sel_n)
    begin
      sh   = sh << 1;
      miso = sh[7];
    end
  // released line shows no stale level
  always @(posedge sel_n)
    miso = ~miso;
endmodule : spi_slave_model
`default_nettype wire

/* testbench/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                  core_clk, rst, ce, tx_write, rx_read;
  logic                  status_clear, rx_irq_en, tx_irq_en;
  logic                  busy, irq, sclk, mosi, miso;
  logic [7:0]            tx_data, rx_data, sw, got;
  logic [3:0]            sel_mask, ssn;
  spi_core_pkg::status_s status;
  spi_core_pkg::status_s s_status;
  logic                  x_sclk, x_mosi, x_sel_n, s_write, s_miso;
  logic [7:0]            s_rx_data, s_got;
  int                    n_mismatch, samples_checked;
  logic [7:0]            tw [4] = '{8'ha5, 8'h01, 8'h80, 8'hff};
  logic [7:0]            sv [4] = '{8'h5a, 8'hc3, 8'h00, 8'h7e};

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  spi_master_slave_core #(.NUM_SLAVES(4), .SCLK_HZ(5_000_000))
  u_spi_master_slave_core (
    .core_clk(core_clk), .rst(rst), .ce(ce), .tx_data(tx_data),
    .tx_write(tx_write), .rx_data(rx_data), .rx_read(rx_read),
    .status_clear(status_clear), .sel_mask(sel_mask),
    .rx_irq_en(rx_irq_en), .tx_irq_en(tx_irq_en), .status(status),
    .busy(busy), .irq(irq), .sclk_out(sclk), .mosi_out(mosi),
    .miso_in(miso), .slave_select_out_m_n(ssn), .sclk_in(1'b0),
    .mosi_in(1'b0), .select_in_n(1'b1), .miso_out()
  );

  // one model stands for whichever single slave is selected
  spi_slave_model u_spi_slave_model (
    .sclk(sclk), .mosi(mosi), .sel_n(&ssn), .miso(miso),
    .word(sw), .got(got)
  );

  // second core in slave role, the bench acts as external master
  spi_master_slave_core #(.IS_MASTER(1'b0), .NUM_SLAVES(4))
  u_spi_master_slave_core_slv (
    .core_clk(core_clk), .rst(rst), .ce(ce), .tx_data(tx_data),
    .tx_write(s_write), .rx_data(s_rx_data), .rx_read(rx_read),
    .status_clear(status_clear), .sel_mask(sel_mask),
    .rx_irq_en(rx_irq_en), .tx_irq_en(tx_irq_en), .status(s_status),
    .busy(), .irq(), .sclk_out(), .mosi_out(), .miso_in(1'b0),
    .slave_select_out_m_n(), .sclk_in(x_sclk), .mosi_in(x_mosi),
    .select_in_n(x_sel_n), .miso_out(s_miso)
  );

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up

  // status bit: 3 word in, 2 ready, 1 overrun
  task automatic wait_flag(input int b);
    int i;
    for (i = 0; i < 400 && status[b] !== 1'b1; i++)
      @(negedge core_clk);
    if (i == 400)
    begin
      n_mismatch++;
      wrap_up();
    end
  endtask : wait_flag

  task automatic send(input logic [7:0] w);
    wait_flag(2);
    tx_data  = w;
    tx_write = 1'b1;
    @(negedge core_clk);
    tx_write = 1'b0;
  endtask : send

  task automatic strobe(input logic clr);
    status_clear = clr;
    rx_read      = !clr;
    @(negedge core_clk);
    {status_clear, rx_read} = 2'b00;
  endtask : strobe

  // one word as external master, mode 0, six cycles per half period
  task automatic drive_slave(input logic [7:0] w);
    x_sel_n = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      x_mosi = w[i];
      repeat (6) @(negedge core_clk);
      s_got  = {s_got[6:0], s_miso};
      x_sclk = 1'b1;
      repeat (6) @(negedge core_clk);
      x_sclk = 1'b0;
    end
    repeat (6) @(negedge core_clk);
    x_sel_n = 1'b1;
    repeat (6) @(negedge core_clk);
  endtask : drive_slave

  initial
  begin
    {rst, ce, tx_write, rx_read, status_clear} = 5'h18;
    {rx_irq_en, tx_irq_en, tx_data, sw, sel_mask} = 22'h0;
    {n_mismatch, samples_checked} = 64'h0;
    {x_sclk, x_mosi, x_sel_n, s_write, s_got} = 12'h200;
    repeat (12) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    check(status, spi_core_pkg::STATUS_RST);
    check({busy, irq, sclk, &ssn}, 4'h1);
    for (int k = 0; k < 4; k++)
    begin
      sel_mask = 4'h1 << k;
      sw       = sv[k];
      send(tw[k]);
      repeat (3) @(negedge core_clk);
      check(ssn, 4'(~sel_mask));
      check(busy, 1'b1);
      wait_flag(3);
      check(rx_data, sv[k]);
      check(got, tw[k]);
      strobe(1'b0);
      check(status[3], 1'b0);
      repeat (8) @(negedge core_clk);
    end
    rx_irq_en = 1'b1;
    sw        = 8'h3c;
    send(8'h11);
    send(8'h22);
    check(status[2], 1'b0);
    wait_flag(3);
    check(rx_data, 8'h3c);
    wait_flag(1);
    check(got, 8'h22);
    check(irq, 1'b1);
    strobe(1'b1);
    check(status[1], 1'b0);
    @(negedge core_clk);
    strobe(1'b0);
    @(negedge core_clk);
    check(irq, 1'b0);
    tx_irq_en = 1'b1;
    repeat (8) @(negedge core_clk);
    check({irq, sclk, &ssn}, 3'h5);
    for (int j = 0; j < 2; j++)
    begin
      tx_data = sv[j];
      s_write = 1'b1;
      @(negedge core_clk);
      s_write = 1'b0;
      drive_slave(tw[j]);
      check(s_rx_data, tw[j]);
      check(s_got, sv[j]);
      check(s_status[3], 1'b1);
      strobe(1'b0);
    end
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
